//--- sim/pmic_register_conventions_irq_status_tb.sv
// self-checking bench for the register bank and its status register
module pmic_register_conventions_irq_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pmic_regs_pkg::*;
  localparam logic [23:0] IMPL = 24'h197FFF;
  localparam logic [23:0] EXT = 24'h186F17;
  localparam logic [23:0] RTC = 24'h0000A0;
  localparam logic [23:0] OFF = 24'h011048;
  logic clk_in, rst_n, rtc_n, off_n, sclk, cs, mosi, miso, start, dupd;
  logic [23:0] ev, st, rv, d, x;
  logic [3:0] mode, ss, live, dval, rw_device_modifiable, lat;
  logic [5:0] a;
  int fails, total_checks;

  serial_host host (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk),
    .cs_out(cs), .mosi_out(mosi));

  pmic_register_bank DUT (.clk_in(clk_in), .rst_n_in(rst_n),
    .clock_power_on_reset_n_in(rtc_n), .off_state_reset_n_in(off_n),
    .sclk_in(sclk), .cs_in(cs), .mosi_in(mosi), .miso_out(miso),
    .main_conv_done_flag_in(ev[0]), .second_conv_done_flag_in(ev[1]),
    .touch_wake_flag_in(ev[2]), .bus_power_valid_flag_in(ev[3]),
    .id_factory_flag_in(ev[4]), .bus_overvoltage_flag_in(ev[5]),
    .charger_attach_flag_in(ev[6]), .charger_fault_flag_in(ev[7]),
    .charge_reverse_flag_in(ev[8]), .charge_short_flag_in(ev[9]),
    .const_current_voltage_flag_in(ev[10]),
    .charge_current_low_flag_in(ev[11]), .battery_turn_on_flag_in(ev[12]),
    .low_battery_lower_flag_in(ev[13]), .low_battery_upper_flag_in(ev[14]),
    .b_session_valid_flag_in(ev[16]), .id_floating_flag_in(ev[19]),
    .id_grounded_flag_in(ev[20]), .start_pulse_in(start),
    .mode_pins_in(mode), .startup_sense_in(ss), .live_sense_in(live),
    .dev_update_in(dupd), .dev_value_in(dval), .status_first_out(st),
    .rw_device_modifiable_out(rw_device_modifiable));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle event pulse, then one clock for the flag to land
  task automatic pulse(input logic [23:0] v);
    ev = v;
    @(posedge clk_in) #1 ev = 24'h000000;
    @(posedge clk_in) #1;
  endtask : pulse

  // expected convention register, version bits left out
  function automatic logic [23:0] conv(logic [3:0] s, logic [3:0] l,
                                       logic [3:0] m);
    return {4'h0, CONV_WIRED, m, live, l, s};
  endfunction : conv

  task automatic summarize();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // watchdog: the whole sequence needs well under 12000 clocks
  initial begin
    repeat (30000) @(posedge clk_in);
    fails++;
    summarize();
  end

  initial begin
    {rst_n, rtc_n, off_n, start, dupd} = 5'h00;
    {ev, mode, ss, live, dval} = 40'h0;
    x = $urandom(32'h442C9819);
    repeat (20) @(posedge clk_in);
    #1 {rst_n, rtc_n, off_n} = 3'h7;
    chk(st, 24'h000000);
    host.frame(1'b0, 6'h00, 24'h000000, rv);
    chk(rv, 24'h000000);
    // plain storage, top register included
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 6'h3F : 6'h01 + 6'($urandom % 54);
      d = 24'($urandom);
      host.frame(1'b1, a, d, x);
      host.frame(1'b0, a, 24'h000000, rv);
      chk(rv, d);
    end
    for (int k = 0; k < 2; k++) begin
      host.frame(1'b1, 6'h37 + 6'(k), 24'hFFFFFF, x);
      host.frame(1'b0, 6'h37 + 6'(k), 24'h000000, rv);
      chk(rv, 24'h000000);
    end
    // every event flag, one at a time, accumulating
    d = 24'h000000;
    for (int b = 0; b < 24; b++) begin
      if (IMPL[b]) begin
        pulse(24'h000001 << b);
        d[b] = 1'b1;
        chk(st, d);
      end
    end
    host.frame(1'b0, 6'h00, 24'h000000, rv);
    chk(rv, IMPL);
    host.frame(1'b1, 6'h00, 24'h000000, x);
    chk(st, IMPL);
    host.frame(1'b1, 6'h00, ~IMPL, x);
    chk(st, IMPL);
    d = 24'($urandom);
    host.frame(1'b1, 6'h00, d, x);
    chk(st, IMPL & ~d);
    pulse(IMPL);
    #0 rtc_n = 1'b0;
    pulse(IMPL);
    chk(st, IMPL & ~RTC);
    rtc_n = 1'b1;
    pulse(RTC);
    chk(st, IMPL);
    off_n = 1'b0;
    @(posedge clk_in) #1 off_n = 1'b1;
    @(posedge clk_in) #1;
    chk(st, IMPL & ~OFF);
    pulse(IMPL);
    rst_n = 1'b0;
    @(posedge clk_in) #1;
    chk(st, IMPL & ~EXT);
    rst_n = 1'b1;
    // strap, latched, live and modifiable fields of the convention register
    mode = 4'($urandom);
    ss = 4'($urandom);
    live = 4'($urandom);
    start = 1'b1;
    @(posedge clk_in) #1 start = 1'b0;
    host.frame(1'b0, 6'h39, 24'h000000, rv);
    chk(rv & 24'h0FFFFF, conv(mode, ss, 4'h0));
    lat = ss;
    ss = ~ss;
    live = ~live;
    host.frame(1'b0, 6'h39, 24'h000000, rv);
    chk(rv & 24'h0FFFFF, conv(mode, lat, 4'h0));
    d = 24'($urandom);
    host.frame(1'b1, 6'h39, d, x);
    host.frame(1'b0, 6'h39, 24'h000000, rv);
    chk(rv & 24'h0FFFFF, conv(d[3:0], lat, d[15:12]));
    dval = 4'($urandom);
    dupd = 1'b1;
    @(posedge clk_in) #1 dupd = 1'b0;
    @(posedge clk_in) #1;
    chk({20'h0, rw_device_modifiable}, {20'h0, dval});
    rst_n = 1'b0;
    @(posedge clk_in) #1 rst_n = 1'b1;
    host.frame(1'b0, 6'h39, 24'h000000, rv);
    chk(rv & 24'h0FFFFF, conv(d[3:0], lat, 4'h0));
    summarize();
  end
endmodule : pmic_register_conventions_irq_status_tb

//--- sim/serial_host.sv
// host model on the serial control bus: 32-bit frames, msb first
module serial_host (
  input wire logic clk_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic cs_out,
  output logic mosi_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // serial clock stands low outside frames
  initial begin
    sclk_out = 1'b0;
    cs_out = 1'b0;
    mosi_out = 1'b0;
  end
  // phases of four clocks keep the three-clock minimum with margin
  task automatic frame(input logic wr, input logic [5:0] addr,
                       input logic [23:0] wd, output logic [23:0] rd);
    logic [31:0] sh;
    sh = {wr, addr, 1'b0, wd};
    rd = 24'h000000;
    @(posedge clk_in) #1 cs_out = 1'b1;
    for (int i = 0; i < 32; i++) begin
      mosi_out = sh[31];
      sh = sh << 1;
      repeat (4) @(posedge clk_in);
      #1;
      // miso settled one clock after the fall, so take it here
      if (i > 7) rd = {rd[22:0], miso_in};
      sclk_out = 1'b1;
      repeat (4) @(posedge clk_in);
      #1 sclk_out = 1'b0;
    end
    repeat (4) @(posedge clk_in);
    #1 cs_out = 1'b0;
    // released data line shows the inverse, never a stale bit
    mosi_out = ~mosi_out;
    // return off the edge so the caller's next drive cannot race it
    repeat (4) @(posedge clk_in);
    #1;
  endtask : frame
endmodule : serial_host

//--- verilog/event_flag.sv
// one sticky event flag with write-one-to-clear and a reset source
module event_flag (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic hold_in,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag_out
);
  // hold keeps the default; an event beats a clear in the same cycle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flag_out <= 1'b0;
    end else if (hold_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clr_in) begin
      flag_out <= 1'b0;
    end
  end

  set_over_clr_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (set_in && !hold_in) |=> flag_out)
    else $error("event lost against clear");
endmodule : event_flag

//--- verilog/pmic_register_bank.sv
// register bank with the first interrupt status register and conventions
// Operation
// - 64 registers, 24 bits each
// - read/write stores; read-only ignores writes
// - write one clears a status flag
// - modifiable bits take host or device updates
// - external reset holds its class at default
// - clock power reset holds class until good
// - off-state pulse returns class to default
// - hardwired and strap bits have no reset
// - strap bits load at start, host writable
// - live sense bits follow input, unlatched
// - latched sense bits capture once at start
// - version bits have no fixed default
// - reserved status bits read zero, read-only
// - registers 55 and 56 not implemented
// - conversion and touch flags, external reset
// - bus valid, attach, turn-on, session: off class
// - overvoltage and charger fault: clock reset class
// - charger path flags 8 to 11
// - low battery thresholds at bits 13, 14
// - id factory, float and ground flags
module pmic_register_bank (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clock_power_on_reset_n_in,
  input wire logic off_state_reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_in,
  input wire logic mosi_in,
  output logic miso_out,
  input wire logic main_conv_done_flag_in,
  input wire logic second_conv_done_flag_in,
  input wire logic touch_wake_flag_in,
  input wire logic bus_power_valid_flag_in,
  input wire logic id_factory_flag_in,
  input wire logic bus_overvoltage_flag_in,
  input wire logic charger_attach_flag_in,
  input wire logic charger_fault_flag_in,
  input wire logic charge_reverse_flag_in,
  input wire logic charge_short_flag_in,
  input wire logic const_current_voltage_flag_in,
  input wire logic charge_current_low_flag_in,
  input wire logic battery_turn_on_flag_in,
  input wire logic low_battery_lower_flag_in,
  input wire logic low_battery_upper_flag_in,
  input wire logic b_session_valid_flag_in,
  input wire logic id_floating_flag_in,
  input wire logic id_grounded_flag_in,
  input wire logic start_pulse_in,
  input wire logic [3:0] mode_pins_in,
  input wire logic [3:0] startup_sense_in,
  input wire logic [3:0] live_sense_in,
  input wire logic dev_update_in,
  input wire logic [3:0] dev_value_in,
  output logic [pmic_regs_pkg::DATA_W-1:0] status_first_out,
  output logic [3:0] rw_device_modifiable_out
);
  import pmic_regs_pkg::*;
  logic wr_stb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] mem_q [REG_COUNT];
  logic [3:0] pin_cfg_q;
  logic [3:0] latch_sense_q;

  serial_frame u_frame (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sclk_in(sclk_in),
    .cs_in(cs_in),
    .mosi_in(mosi_in),
    .rd_data_in(rd_data),
    .miso_out(miso_out),
    .wr_stb_out(wr_stb),
    .addr_out(addr),
    .wr_data_out(wdata)
  );

  // events in status bit order; reserved positions carry no event
  wire [DATA_W-1:0] ev = {
    3'h0, id_grounded_flag_in, id_floating_flag_in,
    2'h0, b_session_valid_flag_in, 1'h0,
    low_battery_upper_flag_in, low_battery_lower_flag_in,
    battery_turn_on_flag_in, charge_current_low_flag_in,
    const_current_voltage_flag_in, charge_short_flag_in,
    charge_reverse_flag_in, charger_fault_flag_in,
    charger_attach_flag_in, bus_overvoltage_flag_in,
    id_factory_flag_in, bus_power_valid_flag_in,
    touch_wake_flag_in, second_conv_done_flag_in,
    main_conv_done_flag_in
  };

  // address decode
  wire hit_status = addr == REG_STATUS_FIRST;
  wire hit_conv = addr == REG_CONVENTION;
  wire hit_unused = addr == REG_UNUSED_A || addr == REG_UNUSED_B;
  // writes come only from complete frames, so a cut frame changes nothing
  wire gen_wr = wr_stb && !hit_status && !hit_conv && !hit_unused;
  wire conv_wr = wr_stb && hit_conv;
  // only ones in the write word clear; zeros leave flags alone
  wire [DATA_W-1:0] clr_vec = (wr_stb && hit_status) ? wdata
                                                     : 24'h000000;
  wire [DATA_W-1:0] rtc_hold =
    {DATA_W{~clock_power_on_reset_n_in}} & RTC_CLASS_MASK;
  wire [DATA_W-1:0] off_hold =
    {DATA_W{~off_state_reset_n_in}} & OFF_CLASS_MASK;
  // a held class ignores its events; the hold is sampled, not asynchronous
  wire [DATA_W-1:0] hold_vec = rtc_hold | off_hold;

  // one flag cell per implemented status bit; reserved bits read zero
  // only the external class uses the pin as an asynchronous reset
  for (genvar i = 0; i < DATA_W; i++) begin : g_flag
    if (STATUS_IMPL_MASK[i]) begin : g_impl
      event_flag u_flag (
        .clk_in(clk_in),
        .arst_n_in(EXT_CLASS_MASK[i] ? rst_n_in : 1'b1),
        .hold_in(hold_vec[i]),
        .set_in(ev[i]),
        .clr_in(clr_vec[i]),
        .flag_out(status_first_out[i])
      );
    end else begin : g_rsvd
      assign status_first_out[i] = 1'b0;
    end
  end

  // plain read/write storage for every other implemented register
  // status, convention and hole slots waste storage to keep the map flat
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int r = 0; r < REG_COUNT; r++) mem_q[r] <= GENERIC_RESET;
    end else if (gen_wr) begin
      mem_q[addr] <= wdata;
    end
  end

  // strap bits: no reset, loaded at start, then host may change them
  always_ff @(posedge clk_in) begin
    if (start_pulse_in) pin_cfg_q <= mode_pins_in;
    else if (conv_wr) pin_cfg_q <= wdata[CONV_PIN_LSB +: 4];
  end

  // startup sense capture; writes from the host never reach it
  always_ff @(posedge clk_in) begin
    if (start_pulse_in) latch_sense_q <= startup_sense_in;
  end

  // check helper: latched fields stay unknown until a first start pulse
  logic start_seen_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_seen_q <= 1'b0;
    end else if (start_pulse_in) begin
      start_seen_q <= 1'b1;
    end
  end

  // device update wins over a host write in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rw_device_modifiable_out <= MODIFY_RESET;
    end else if (dev_update_in) begin
      rw_device_modifiable_out <= dev_value_in;
    end else if (conv_wr) begin
      rw_device_modifiable_out <= wdata[CONV_MODIFY_LSB +: 4];
    end
  end

  // convention register image; version field is not a fixed default
  wire [DATA_W-1:0] conv_rd = {
    CONV_VERSION,
    CONV_WIRED,
    rw_device_modifiable_out,
    live_sense_in,
    latch_sense_q,
    pin_cfg_q
  };

  // read selection; unimplemented registers answer zero
  // the frame takes its snapshot one clock after the address arrives
  assign rd_data = hit_status ? status_first_out :
                   hit_conv ? conv_rd :
                   hit_unused ? 24'h000000 : mem_q[addr];

  // checks run on the system clock; all but the two pin reset checks rest while the pin reset is low
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // a one in the write word empties the flag when nothing else acts
  w1c_clear_a: assert property (
    (clr_vec != 24'h000000 && ev == 24'h000000 && hold_vec == 24'h000000)
    |=> (status_first_out & $past(clr_vec)) == 24'h000000)
    else $error("write one did not clear flag");

  // zeros in the write word must leave every flag as it was
  w0_keep_a: assert property (
    (wr_stb && hit_status && ev == 24'h000000 && hold_vec == 24'h000000)
    |=> (status_first_out & ~$past(wdata)) ==
        ($past(status_first_out) & ~$past(wdata)))
    else $error("write zero changed flag");

  // an event lands on the next edge unless a hold is active
  set_flag_a: assert property (
    (ev != 24'h000000 && hold_vec == 24'h000000)
    |=> (status_first_out & $past(ev)) == $past(ev))
    else $error("event did not set flag");

  // two low samples of the clock power reset force its class low
  rtc_hold_a: assert property (
    !clock_power_on_reset_n_in [*2]
    |-> (status_first_out & RTC_CLASS_MASK) == 24'h000000)
    else $error("clock reset class not held");

  // a single low cycle of the off pulse is enough to clear its class
  off_hold_a: assert property (
    !off_state_reset_n_in
    |=> (status_first_out & OFF_CLASS_MASK) == 24'h000000)
    else $error("off class not returned to default");

  // reserved status positions never read as one
  rsvd_zero_a: assert property (
    hit_status |-> (rd_data & ~STATUS_IMPL_MASK) == 24'h000000)
    else $error("reserved status bit reads one");

  // plain storage returns what was written
  rw_store_a: assert property (
    gen_wr |=> mem_q[$past(addr)] == $past(wdata))
    else $error("read/write register lost data");

  // the two holes in the map answer zero
  unused_zero_a: assert property (
    (hit_unused ##1 wr_stb && hit_unused) |=> rd_data == 24'h000000)
    else $error("unused register holds data");

  // a device update always lands, even against a host write
  rwm_dev_a: assert property (
    dev_update_in |=> rw_device_modifiable_out == $past(dev_value_in))
    else $error("device update missed");

  // a start pulse copies the strap pins
  pin_load_a: assert property (
    start_pulse_in |=> pin_cfg_q == $past(mode_pins_in))
    else $error("strap bits not loaded");

  // between start pulses the latched sense field stays put
  latch_keep_a: assert property (
    (start_seen_q && !start_pulse_in ##1 !start_pulse_in)
    |-> latch_sense_q == $past(latch_sense_q))
    else $error("latched sense moved");

  // the live sense field is shown as it stands, never latched
  live_sense_a: assert property (
    hit_conv |-> rd_data[CONV_SENSE_LSB +: 4] == live_sense_in)
    else $error("live sense not shown");

  // side paths: straps, latched sense, the modifiable field, holes and the reset classes
  // the pin reset holds the external class at zero while it stays low
  ext_hold_a: assert property (
    disable iff (1'b0)
    !rst_n_in [*2] |-> (status_first_out & EXT_CLASS_MASK) == 24'h000000)
    else $error("external class not held");

  // the modifiable field sits in the external class as well
  rwm_reset_a: assert property (
    disable iff (1'b0)
    !rst_n_in [*2] |-> rw_device_modifiable_out == MODIFY_RESET)
    else $error("modifiable field not reset");

  // a host write reaches the modifiable field when the device is quiet
  rwm_host_a: assert property (
    (conv_wr && !dev_update_in)
    |=> rw_device_modifiable_out == $past(wdata[CONV_MODIFY_LSB +: 4]))
    else $error("host write to modifiable field lost");

  // after the start load the host may rewrite the strap field
  pin_host_a: assert property (
    (conv_wr && !start_pulse_in)
    |=> pin_cfg_q == $past(wdata[CONV_PIN_LSB +: 4]))
    else $error("host write to strap field lost");

  // a start pulse captures the startup sense inputs
  latch_load_a: assert property (
    start_pulse_in |=> latch_sense_q == $past(startup_sense_in))
    else $error("startup sense not captured");

  // host writes leave the latched sense field alone
  latch_ro_a: assert property (
    (start_seen_q && conv_wr && !start_pulse_in)
    |=> latch_sense_q == $past(latch_sense_q))
    else $error("host wrote a read-only field");

  // writes aimed at the two holes never reach the storage array
  unused_keep_a: assert property (
    (wr_stb && hit_unused) |=> mem_q[$past(addr)] == $past(mem_q[addr]))
    else $error("write landed in an unused register");

  // any hold beats an event landing in the same cycle
  hold_win_a: assert property (
    (hold_vec != 24'h000000)
    |=> (status_first_out & $past(hold_vec)) == 24'h000000)
    else $error("held flag set by an event");
endmodule : pmic_register_bank

//--- verilog/pmic_regs_pkg.sv
// constants and types shared by the power-management register bank
package pmic_regs_pkg;
  localparam int DATA_W = 24;
  localparam int ADDR_W = 6;
  localparam int REG_COUNT = 64;
  // serial frame: write bit, 6 address bits, one null bit, 24 data bits
  localparam logic [5:0] HEAD_BITS = 6'h08;
  localparam logic [5:0] FRAME_BITS = 6'h20;
  // register numbers
  localparam logic [5:0] REG_STATUS_FIRST = 6'h00;
  localparam logic [5:0] REG_UNUSED_A = 6'h37;
  localparam logic [5:0] REG_UNUSED_B = 6'h38;
  localparam logic [5:0] REG_CONVENTION = 6'h39;
  // reset values
  localparam logic [23:0] STATUS_RESET = 24'h000000;
  localparam logic [23:0] GENERIC_RESET = 24'h000000;
  localparam logic [3:0] MODIFY_RESET = 4'h0;
  // first status register: reset-source class of each flag
  localparam logic [23:0] EXT_CLASS_MASK = 24'h186F17;
  localparam logic [23:0] RTC_CLASS_MASK = 24'h0000A0;
  localparam logic [23:0] OFF_CLASS_MASK = 24'h011048;
  localparam logic [23:0] STATUS_IMPL_MASK = 24'h197FFF;
  // convention register field positions, four bits each
  localparam int CONV_PIN_LSB = 0;
  localparam int CONV_LATCH_LSB = 4;
  localparam int CONV_SENSE_LSB = 8;
  localparam int CONV_MODIFY_LSB = 12;
  localparam int CONV_WIRED_LSB = 16;
  localparam int CONV_VERSION_LSB = 20;
  localparam logic [3:0] CONV_WIRED = 4'hA;
  // version field value is arbitrary
  localparam logic [3:0] CONV_VERSION = 4'h3;
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_ADDR = 2'b01,
    FR_DATA = 2'b11
  } frame_state_t;
endpackage : pmic_regs_pkg

//--- verilog/serial_frame.sv
// serial control bus slave: 32-bit frames, read data in the same frame
module serial_frame (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_in,
  input wire logic mosi_in,
  input wire logic [pmic_regs_pkg::DATA_W-1:0] rd_data_in,
  output logic miso_out,
  output logic wr_stb_out,
  output logic [pmic_regs_pkg::ADDR_W-1:0] addr_out,
  output logic [pmic_regs_pkg::DATA_W-1:0] wr_data_out
);
  import pmic_regs_pkg::*;
  frame_state_t state_q, state_d;
  logic sclk_prev_q;
  logic [5:0] cnt_q;
  logic [23:0] out_q;
  logic rw_q;
  logic load_q;
  wire rise = sclk_in & ~sclk_prev_q;
  wire fall = ~sclk_in & sclk_prev_q;
  wire head_done = (state_q == FR_ADDR) && (state_d == FR_DATA);
  // a write lands only for a complete frame, never a cut one
  wire commit = (state_q == FR_DATA) && !cs_in && (cnt_q == FRAME_BITS);

  always_comb begin
    state_d = state_q;
    case (state_q)
      FR_IDLE: if (cs_in) state_d = FR_ADDR;
      FR_ADDR: begin
        if (!cs_in) state_d = FR_IDLE;
        else if (cnt_q == HEAD_BITS) state_d = FR_DATA;
      end
      FR_DATA: if (!cs_in) state_d = FR_IDLE;
      default: state_d = FR_IDLE;
    endcase
  end

  // frame state, bit count and edge history
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= FR_IDLE;
      sclk_prev_q <= 1'b0;
      cnt_q <= 6'h00;
    end else begin
      state_q <= state_d;
      sclk_prev_q <= sclk_in;
      if (state_q == FR_IDLE) cnt_q <= 6'h00;
      else if (rise && cnt_q != FRAME_BITS) cnt_q <= cnt_q + 6'h01;
    end
  end

  // the last 24 bits shifted in are the write data
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_data_out <= 24'h000000;
      addr_out <= 6'h00;
      rw_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      if (rise && state_q != FR_IDLE) begin
        wr_data_out <= {wr_data_out[22:0], mosi_in};
      end
      if (head_done) begin
        rw_q <= wr_data_out[7];
        addr_out <= wr_data_out[6:1];
      end
      load_q <= head_done;
    end
  end

  // read word is fetched one cycle after the address, before any fall
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_q <= 24'h000000;
      miso_out <= 1'b0;
      wr_stb_out <= 1'b0;
    end else begin
      if (load_q) out_q <= rd_data_in;
      else if (fall && state_q == FR_DATA) out_q <= {out_q[22:0], 1'b0};
      if (state_q == FR_IDLE) miso_out <= 1'b0;
      else if (fall && state_q == FR_DATA && !load_q) miso_out <= out_q[23];
      wr_stb_out <= commit && rw_q;
    end
  end

  wr_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_stb_out |-> $past(cnt_q) == FRAME_BITS && $past(rw_q))
    else $error("write without full frame");
endmodule : serial_frame
